// ---- core/auto_sense_mux_sequencer.sv ----
// sense multiplexer sequencer with registers, sync pulse and bypass monitor
// How it works
// RULE1 - channel timing follows selected pwm clock
// RULE2 - clearing then setting run bit realigns pwm
// RULE3 - reference every 1024 ticks; sweep waits one
// RULE4 - sweep starts on channel 0
// RULE5 - advance channel one tick after sync falls
// RULE6 - sync lasts eight ticks for partial duty
// RULE7 - nine ticks when full, off or late
// RULE8 - permanent channels pulse 11 ticks after previous
// RULE9 - delay 11b then 00b postpones one period
// RULE10 - sweep runs once, then clears its bit
// RULE11 - writing sweep bit zero aborts sweep
// RULE12 - select writes ignored while sweep bit set
// RULE13 - off channel sync pulse floats the mux
// RULE14 - host orders phase shifts ascending from channel 0
// RULE15 - selected channel bypass compare reported
// RULE16 - level bit picks open-load source current
// RULE17 - host does select, enable, read, disable
// RULE18 - sync only while pwm runs, after delay
// RULE19 - outside sweep, select field routes sensing
// RULE20 - channels 0 to 3 ascending, end after 3
// RULE21 - sync low whenever no pulse runs
//
// Local design decisions: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module auto_sense_mux_sequencer #(
	parameter int ADDR_W  = 8,
	parameter int INT_DIV = 1
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              ext_pwm_clk,
	input  wire logic [3:0]        vds_low,
	output logic [3:0]             channel_on,
	output logic                   sense_sync_output,
	output logic [2:0]             sense_mux_sel,
	output logic                   sense_enable,
	output logic                   mux_hiz,
	output logic                   bypass_monitor_bit,
	output logic                   diag_bypass,
	output logic                   openload_source_enable,
	output logic                   source_level_bit,
	output logic                   pwm_run_bit
);
	typedef enum logic [2:0] {
		S_IDLE, S_GAP, S_WAIT_ACT, S_DELAY, S_PULSE, S_ADVANCE
	} seq_state_t;

	////////////////////////////////////////////////////////////////////////////////
	// field helpers

	function automatic logic [10:0] duty_of(input logic [31:0] w);
		duty_of = w[amux_pkg::CH_DUTY_LSB +: 11];
	endfunction

	function automatic logic [1:0] delay_of(input logic [31:0] w);
		delay_of = w[amux_pkg::CH_DELAY_LSB +: 2];
	endfunction

	function automatic logic perm_of(input logic [31:0] w);
		perm_of = (duty_of(w) == 11'h000) || (duty_of(w) >= amux_pkg::PWM_PERIOD);
	endfunction

	function automatic logic on_at(input logic [31:0] w, input logic [9:0] cnt);
		logic [9:0] ofs;
		ofs   = cnt - w[amux_pkg::CH_PHASE_LSB +: 10];
		on_at = {1'b0, ofs} < duty_of(w);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b])
				merge[8*b +: 8] = nw[8*b +: 8];
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus port and register map

	logic              wr_en;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0]       wr_data;
	logic [3:0]        wr_strb;
	logic [ADDR_W-1:0] rd_addr;
	logic [31:0]       rd_data;
	logic              wr_err;
	logic              rd_err;

	axil_reg_port #(.ADDR_W(ADDR_W)) bus (
		.clk     (clk),
		.rst     (rst),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.wr_en   (wr_en),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_err  (wr_err),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	logic        use_ext;
	logic        auto_sweep_bit;
	logic [2:0]  sense_select_field;
	logic [31:0] ch_cfg [amux_pkg::NUM_CH];

	wire [7:0]  wa        = 8'(wr_addr);
	wire [7:0]  ra        = 8'(rd_addr);
	wire        wa_ctrl   = (wa == amux_pkg::CTRL_OFS);
	wire        wa_stat   = (wa == amux_pkg::STATUS_OFS);
	wire        wa_ch     = (wa >= amux_pkg::CH0_OFS) && (wa <= amux_pkg::CH3_OFS)
	                        && (wa[1:0] == 2'h0);
	wire [1:0]  wa_idx    = wa[3:2];
	wire        ra_ctrl   = (ra == amux_pkg::CTRL_OFS);
	wire        ra_stat   = (ra == amux_pkg::STATUS_OFS);
	wire        ra_ch     = (ra >= amux_pkg::CH0_OFS) && (ra <= amux_pkg::CH3_OFS)
	                        && (ra[1:0] == 2'h0);
	wire [1:0]  ra_idx    = ra[3:2];
	wire        ctrl_wr   = wr_en && wa_ctrl;

	logic [31:0] ctrl_word;
	logic [31:0] next_ctrl;
	logic [31:0] status_word;

	assign wr_err = !(wa_ctrl || wa_stat || wa_ch);
	assign rd_err = !(ra_ctrl || ra_stat || ra_ch);
	assign next_ctrl = merge(ctrl_word, wr_data, wr_strb);

	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[amux_pkg::CTRL_RUN_BIT] = pwm_run_bit;
		ctrl_word[amux_pkg::CTRL_EXT_BIT] = use_ext;
		ctrl_word[amux_pkg::CTRL_AUTO_BIT] = auto_sweep_bit;
		ctrl_word[amux_pkg::CTRL_SEL_LSB +: 3] = sense_select_field;
		ctrl_word[amux_pkg::CTRL_OLS_BIT] = openload_source_enable;
		ctrl_word[amux_pkg::CTRL_LVL_BIT] = source_level_bit;
	end

	assign rd_data = ra_ctrl ? ctrl_word :
	                 ra_stat ? status_word :
	                 ra_ch   ? ch_cfg[ra_idx] : 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// pwm time base and channel activation

	logic       tick;
	logic [9:0] count;
	logic       ref_point;
	logic [3:0] act_prev;
	logic [3:0] act_rise;
	logic [3:0] perm;

	pwm_timebase #(.INT_DIV(INT_DIV)) timebase (
		.clk         (clk),
		.rst         (rst),
		.run         (pwm_run_bit),
		.use_ext     (use_ext),
		.ext_pwm_clk (ext_pwm_clk),
		.tick        (tick),
		.count       (count),
		.ref_point   (ref_point)
	);

	always_comb begin
		for (int i = 0; i < amux_pkg::NUM_CH; i++) begin
			channel_on[i] = pwm_run_bit && on_at(ch_cfg[i], count); // [RULE1]
			perm[i]       = perm_of(ch_cfg[i]);
		end
	end

	assign act_rise = {4{tick}} & channel_on & ~act_prev;

	always_ff @(posedge clk) begin
		if (rst)
			act_prev <= 4'h0;
		else if (tick || !pwm_run_bit)
			act_prev <= channel_on;
	end

	////////////////////////////////////////////////////////////////////////////////
	// sweep sequencer

	seq_state_t state;
	logic [1:0] ch;
	logic [9:0] wait_cnt;
	logic       pulse_long;
	logic       postpone;
	logic       sync;

	wire       sweeping   = (state != S_IDLE);
	wire       stop_sweep = !auto_sweep_bit || !pwm_run_bit; // [RULE11]
	wire [1:0] ch_next    = ch + 2'h1;
	wire [9:0] delay_tk   = 10'({8'h00, delay_of(ch_cfg[ch])} * amux_pkg::SYNC_DELAY_STEP);
	wire       late       = pulse_long || !channel_on[ch]; // [RULE7]
	wire       sweep_done = tick && (state == S_ADVANCE) && (ch == 2'h3) && !stop_sweep;
	wire       skip_next  = (delay_of(ch_cfg[ch]) == amux_pkg::DELAY_MAX)
	                        && (delay_of(ch_cfg[ch_next]) < amux_pkg::DELAY_MIN_NEXT);

	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= S_IDLE;
			ch         <= 2'h0;
			wait_cnt   <= 10'h000;
			pulse_long <= 1'b0;
			postpone   <= 1'b0;
			sync       <= 1'b0;
		end else if (sweeping && stop_sweep) begin
			state <= S_IDLE; // [RULE11]
			sync  <= 1'b0; // [RULE21]
			ch    <= 2'h0;
		end else if (tick) begin
			unique case (state)
				S_IDLE: if (auto_sweep_bit && ref_point) begin // [RULE3]
					ch       <= 2'h0; // [RULE4]
					postpone <= 1'b0;
					wait_cnt <= amux_pkg::PERM_GAP - 10'h001;
					state    <= perm[0] ? S_GAP : S_WAIT_ACT;
				end
				S_GAP: if (wait_cnt == 10'h000) begin
					state      <= S_PULSE; // [RULE8]
					sync       <= 1'b1;
					pulse_long <= 1'b1;
					wait_cnt   <= amux_pkg::SYNC_LONG - 10'h001;
				end else begin
					wait_cnt <= wait_cnt - 10'h001;
				end
				S_WAIT_ACT: if (postpone) begin
					if (ref_point)
						postpone <= 1'b0; // [RULE9]
				end else if (act_rise[ch]) begin
					pulse_long <= 1'b0;
					if (delay_tk == 10'h000) begin
						state    <= S_PULSE; // [RULE18]
						sync     <= 1'b1;
						wait_cnt <= amux_pkg::SYNC_SHORT - 10'h001;
					end else begin
						state    <= S_DELAY;
						wait_cnt <= delay_tk - 10'h001;
					end
				end
				S_DELAY: begin
					pulse_long <= late;
					if (wait_cnt == 10'h000) begin
						state    <= S_PULSE; // [RULE18]
						sync     <= 1'b1;
						wait_cnt <= late ? amux_pkg::SYNC_LONG - 10'h001
						                 : amux_pkg::SYNC_SHORT - 10'h001; // [RULE6] [RULE7]
					end else begin
						wait_cnt <= wait_cnt - 10'h001;
					end
				end
				S_PULSE: if (wait_cnt == 10'h000) begin
					sync  <= 1'b0;
					state <= S_ADVANCE;
				end else begin
					wait_cnt <= wait_cnt - 10'h001;
				end
				S_ADVANCE: if (ch == 2'h3) begin
					state <= S_IDLE; // [RULE20]
				end else begin
					ch       <= ch_next; // [RULE5] [RULE20]
					postpone <= skip_next; // [RULE9]
					wait_cnt <= amux_pkg::PERM_GAP - 10'h002;
					state    <= perm[ch_next] ? S_GAP : S_WAIT_ACT;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers

	always_ff @(posedge clk) begin
		if (rst) begin
			pwm_run_bit            <= 1'b0;
			use_ext                <= 1'b0;
			auto_sweep_bit         <= 1'b0;
			sense_select_field     <= amux_pkg::SEL_DISABLE;
			openload_source_enable <= 1'b0;
			source_level_bit       <= 1'b0;
		end else begin
			if (ctrl_wr) begin
				pwm_run_bit            <= next_ctrl[amux_pkg::CTRL_RUN_BIT]; // [RULE2]
				use_ext                <= next_ctrl[amux_pkg::CTRL_EXT_BIT]; // [RULE1]
				openload_source_enable <= next_ctrl[amux_pkg::CTRL_OLS_BIT];
				source_level_bit       <= next_ctrl[amux_pkg::CTRL_LVL_BIT]; // [RULE16]
				if (!auto_sweep_bit)
					sense_select_field <= next_ctrl[amux_pkg::CTRL_SEL_LSB +: 3]; // [RULE12]
			end
			// a host write in the finishing cycle wins over the self-clear
			if (ctrl_wr)
				auto_sweep_bit <= next_ctrl[amux_pkg::CTRL_AUTO_BIT]; // [RULE11]
			else if (sweep_done)
				auto_sweep_bit <= 1'b0; // [RULE10]
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < amux_pkg::NUM_CH; i++)
				ch_cfg[i] <= amux_pkg::CH_RESET;
		end else if (wr_en && wa_ch) begin
			ch_cfg[wa_idx] <= merge(ch_cfg[wa_idx], wr_data, wr_strb) & amux_pkg::CH_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// multiplexer, sync and bypass outputs

	wire [2:0] next_sel  = sweeping ? {1'b0, ch} : sense_select_field; // [RULE19]
	wire       sel_valid = !next_sel[2];
	wire       next_hiz  = sweeping && sync && (duty_of(ch_cfg[ch]) == 11'h000); // [RULE13]

	assign sense_sync_output = sync && sweeping && pwm_run_bit && auto_sweep_bit; // [RULE18]
	assign sense_mux_sel     = next_sel;
	assign mux_hiz           = next_hiz;
	assign sense_enable      = sel_valid && !next_hiz; // [RULE19]
	assign diag_bypass       = bypass_monitor_bit;

	always_ff @(posedge clk) begin
		if (rst)
			bypass_monitor_bit <= 1'b0;
		else
			bypass_monitor_bit <= sel_valid && vds_low[next_sel[1:0]]; // [RULE15]
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[amux_pkg::STAT_BYP_BIT] = bypass_monitor_bit;
		status_word[amux_pkg::STAT_BUSY_BIT] = sweeping;
		status_word[amux_pkg::STAT_CH_LSB +: 2] = ch;
		status_word[amux_pkg::STAT_SEL_LSB +: 3] = next_sel;
		status_word[amux_pkg::STAT_SYNC_BIT] = sense_sync_output;
		status_word[amux_pkg::STAT_ON_LSB +: 4] = channel_on;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	logic [3:0] pulse_ticks;

	always_ff @(posedge clk) begin
		if (rst || !sync)
			pulse_ticks <= 4'h0;
		else if (tick)
			pulse_ticks <= pulse_ticks + 4'h1;
	end

	sync_len_a: assert property (@(posedge clk) disable iff (rst) // [RULE6] [RULE7]
		$fell(sync) && state == S_ADVANCE |-> pulse_ticks == (pulse_long ? 4'h9 : 4'h8))
		else $error("sync pulse length wrong");

	sync_idle_a: assert property (@(posedge clk) disable iff (rst) // [RULE21]
		!sweeping |-> !sense_sync_output)
		else $error("sync high while sweep idle");

	sync_run_a: assert property (@(posedge clk) disable iff (rst) // [RULE18]
		sense_sync_output |-> pwm_run_bit && auto_sweep_bit)
		else $error("sync high without pwm run");

	sweep_start_a: assert property (@(posedge clk) disable iff (rst) // [RULE3] [RULE4]
		$rose(sweeping) |-> $past(ref_point) && ch == 2'h0 && sense_mux_sel == 3'h0)
		else $error("sweep started wrongly");

	chan_advance_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
		state == S_ADVANCE && tick && ch != 2'h3 && !stop_sweep |=> ch == $past(ch) + 2'h1)
		else $error("channel did not advance");

	sweep_clear_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
		sweep_done && !ctrl_wr |=> !auto_sweep_bit ##1 !sweeping)
		else $error("sweep bit not cleared");

	select_lock_a: assert property (@(posedge clk) disable iff (rst) // [RULE12]
		auto_sweep_bit |=> $stable(sense_select_field))
		else $error("select changed during sweep");

	hiz_off_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
		mux_hiz |-> sync && duty_of(ch_cfg[ch]) == 11'h000 && !sense_enable)
		else $error("mux floated outside off-channel pulse");

	bypass_sel_a: assert property (@(posedge clk) disable iff (rst) // [RULE15]
		sel_valid |=> bypass_monitor_bit == $past(vds_low[next_sel[1:0]]))
		else $error("bypass bit not from selected channel");

	abort_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
		sweeping && !auto_sweep_bit |=> !sweeping && !sense_sync_output)
		else $error("sweep not aborted");
endmodule

// ---- core/amux_pkg.sv ----
// constants for the automatic sense multiplexer sequencer
package amux_pkg;
	// pwm timing, counted in pwm clock ticks
	localparam logic [10:0] PWM_PERIOD      = 11'h400;
	localparam logic [9:0]  PWM_LAST        = 10'h3ff;
	localparam logic [9:0]  SYNC_SHORT      = 10'h008;
	localparam logic [9:0]  SYNC_LONG       = 10'h009;
	localparam logic [9:0]  PERM_GAP        = 10'h00b;
	localparam logic [9:0]  SYNC_DELAY_STEP = 10'h010;
	localparam logic [1:0]  DELAY_MAX       = 2'h3;
	localparam logic [1:0]  DELAY_MIN_NEXT  = 2'h1;
	localparam int          NUM_CH          = 4;

	// register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CH0_OFS    = 8'h10;
	localparam logic [7:0] CH3_OFS    = 8'h1c;

	// control word fields
	localparam int CTRL_RUN_BIT  = 0;
	localparam int CTRL_EXT_BIT  = 1;
	localparam int CTRL_AUTO_BIT = 2;
	localparam int CTRL_SEL_LSB  = 4;
	localparam int CTRL_OLS_BIT  = 8;
	localparam int CTRL_LVL_BIT  = 9;

	// status word fields
	localparam int STAT_BYP_BIT  = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int STAT_CH_LSB   = 2;
	localparam int STAT_SEL_LSB  = 4;
	localparam int STAT_SYNC_BIT = 8;
	localparam int STAT_ON_LSB   = 16;

	// channel word fields
	localparam int CH_DUTY_LSB  = 0;
	localparam int CH_PHASE_LSB = 16;
	localparam int CH_DELAY_LSB = 28;
	localparam logic [31:0] CH_MASK = 32'h33ff_07ff;

	// reset values; select field resets to sensing disabled
	localparam logic [2:0]  SEL_DISABLE = 3'h6;
	localparam logic [31:0] CH_RESET    = 32'h0000_0000;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- core/pwm_timebase.sv ----
// pwm tick source and 1024-tick reference counter
`timescale 1ns/10ps
module pwm_timebase #(
	parameter int INT_DIV = 1
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic       use_ext,
	input  wire logic       ext_pwm_clk,
	output logic            tick,
	output logic [9:0]      count,
	output logic            ref_point
);
	logic        ext_prev;
	logic [15:0] div_cnt;
	wire         ext_edge = ext_pwm_clk && !ext_prev;
	wire         int_tick = (div_cnt == 16'(INT_DIV - 1));

	assign tick      = run && (use_ext ? ext_edge : int_tick); // [RULE1]
	assign ref_point = tick && (count == amux_pkg::PWM_LAST); // [RULE3]

	always_ff @(posedge clk) begin
		if (rst) begin
			ext_prev <= 1'b0;
			div_cnt  <= 16'h0000;
			count    <= 10'h000;
		end else begin
			ext_prev <= ext_pwm_clk;
			div_cnt  <= (int_tick || !run) ? 16'h0000 : div_cnt + 16'h0001;
			// dropping run realigns the period to the host
			if (!run)
				count <= 10'h000; // [RULE2]
			else if (tick)
				count <= count + 10'h001;
		end
	end

	ref_wrap_a: assert property (@(posedge clk) disable iff (rst) // [RULE3]
		ref_point |=> count == 10'h000)
		else $error("count did not wrap after reference point");
endmodule

// ---- core/axil_reg_port.sv ----
// axi4-lite slave front end with single-cycle register strobes
`timescale 1ns/10ps
module axil_reg_port #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic                   wr_en,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_err,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_err
);
	logic aw_held;
	logic w_held;

	assign awready = !aw_held;
	assign wready  = !w_held;
	assign arready = !rvalid;
	assign wr_en   = aw_held && w_held && !bvalid;
	assign rd_addr = araddr;

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= amux_pkg::RESP_OKAY;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held  <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (wr_en) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_err ? amux_pkg::RESP_SLVERR : amux_pkg::RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= amux_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_data;
			rresp  <= rd_err ? amux_pkg::RESP_SLVERR : amux_pkg::RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end
endmodule

// ---- tb/sense_far_side.sv ----
// far side model: external pwm clock and bypass comparators
`timescale 1ns/10ps
module sense_far_side (
	input  wire logic       clk,
	output logic            ext_pwm_clk,
	output logic [3:0]      vds_low
);
	initial ext_pwm_clk = 1'b0;
	// one pwm tick every two clocks
	always @(posedge clk) begin
		ext_pwm_clk <= ~ext_pwm_clk;
	end
	assign vds_low = 4'h5;
endmodule

// ---- tb/tb.sv ----
// bench for the sense multiplexer sequencer
`timescale 1ns/10ps
module tb;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, vds_low, channel_on;
	logic [1:0]  bresp, rresp, r, bq;
	logic        awready, wready, bvalid, arready, rvalid, ext_pwm_clk;
	logic        sense_sync_output, sense_enable, mux_hiz, bypass_monitor_bit, diag_bypass;
	logic        openload_source_enable, source_level_bit, pwm_run_bit;
	logic [2:0]  sense_mux_sel;
	int          n_fail, check_count, cyc, hi, lo;
	int          len_q[$], gap_q[$];
	logic [2:0]  sel_q[$];
	logic        hiz_q[$];
	auto_sense_mux_sequencer #(.ADDR_W(8), .INT_DIV(1)) auto_sense_mux_sequencer_i (
		.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ext_pwm_clk(ext_pwm_clk), .vds_low(vds_low),
		.channel_on(channel_on), .sense_sync_output(sense_sync_output),
		.sense_mux_sel(sense_mux_sel), .sense_enable(sense_enable), .mux_hiz(mux_hiz),
		.bypass_monitor_bit(bypass_monitor_bit), .diag_bypass(diag_bypass),
		.openload_source_enable(openload_source_enable),
		.source_level_bit(source_level_bit), .pwm_run_bit(pwm_run_bit));
	sense_far_side sense_far_side_i (.clk(clk), .ext_pwm_clk(ext_pwm_clk), .vds_low(vds_low));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			finish_test();
		end
	end
	// sync pulse lengths, gaps, select and float at each rise
	always @(posedge clk) begin
		if (sense_sync_output === 1'b1) begin
			if (hi == 0) begin
				sel_q.push_back(sense_mux_sel);
				hiz_q.push_back(mux_hiz);
				gap_q.push_back(lo);
			end
			hi++;
			lo = 0;
		end else begin
			if (hi != 0) len_q.push_back(hi);
			hi = 0;
			lo++;
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (pa && awready) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1) @(posedge clk);
		bq = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic sweep(input logic [31:0] c, input int m, input int l0, input logic h0,
			input int l1, input int g1, input logic h1);
		int k, el;
		logic eh;
		len_q = {};
		sel_q = {};
		hiz_q = {};
		gap_q = {};
		wr(8'h00, c | 32'h65);
		wr(8'h00, c | 32'h15);
		k = 0;
		while (len_q.size() < 4 && k < 8000) begin
			@(posedge clk);
			k++;
		end
		for (int i = 0; i < 4; i++) begin
			el = (i == 0) ? l0 : (i == 1) ? l1 : 9 * m;
			eh = (i == 0) ? h0 : (i == 1) ? h1 : 1'b1;
			chk("pulse length", el, len_q[i]);
			chk("sweep channel", i, sel_q[i]);
			chk("float", eh, hiz_q[i]);
			if (i != 0) chk("gap", (i == 1) ? g1 : 11 * m, gap_q[i]);
		end
		rd(8'h00);
		chk("auto clear", 0, d[2]);
		chk("run kept", 1, pwm_run_bit);
		chk("select kept", 6, d[6:4]);
		chk("sync idle", 0, sense_sync_output);
		wr(8'h00, 32'h0);
	endtask
	task automatic abort_sweep();
		int k;
		k = 0;
		wr(8'h00, 32'h65);
		while (sense_sync_output !== 1'b1 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		chk("abort armed", 1, sense_sync_output);
		wr(8'h00, 32'h61);
		repeat (2) @(posedge clk);
		chk("abort sync", 0, sense_sync_output);
		len_q = {};
		repeat (2100) @(posedge clk);
		chk("aborted pulses", 0, len_q.size());
		rd(8'h04);
		chk("busy", 0, d[1]);
		wr(8'h00, 32'h0);
	endtask
	task automatic regs_and_bypass();
		rd(8'h00);
		chk("ctrl reset", 32'h60, d);
		chk("channel idle", 0, channel_on);
		chk("run reset", 0, pwm_run_bit);
		rd(8'h40);
		chk("unmapped read", 2, r);
		wr(8'h40, 32'h1);
		chk("unmapped write", 2, bq);
		wr(8'h00, 32'h300);
		repeat (3) @(posedge clk);
		chk("mux sel", 0, sense_mux_sel);
		chk("sense on", 1, sense_enable);
		chk("bypass", vds_low[0], bypass_monitor_bit);
		chk("diag", vds_low[0], diag_bypass);
		chk("source", 1, openload_source_enable);
		chk("level", 1, source_level_bit);
		rd(8'h04);
		chk("status bypass", vds_low[0], d[0]);
		wr(8'h00, 32'h10);
		repeat (3) @(posedge clk);
		chk("bypass ch1", vds_low[1], bypass_monitor_bit);
		chk("source off", 0, openload_source_enable);
		chk("level low", 0, source_level_bit);
		wr(8'h00, 32'h60);
		repeat (3) @(posedge clk);
		chk("sense off", 0, sense_enable);
		chk("bypass none", 0, bypass_monitor_bit);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		chk("sync reset", 0, sense_sync_output);
		regs_and_bypass();
		sweep(32'h0, 1, 9, 1'b1, 9, 11, 1'b1);
		sweep(32'h2, 2, 18, 1'b1, 18, 22, 1'b1);
		wr(8'h10, 32'h0000_0200);
		sweep(32'h0, 1, 8, 1'b0, 9, 11, 1'b1);
		wr(8'h10, 32'h3000_0008);
		wr(8'h14, 32'h0100_0200);
		sweep(32'h0, 1, 9, 1'b0, 8, 199 + 1024, 1'b0);
		abort_sweep();
		finish_test();
	end
endmodule
